// ==== core/bet_core.sv ====
/*
   bet_core: sequences branch instructions and direct push, pop and
   exchange accesses, holding the core busy for the documented states.
   Assumes the decoder presents one operation with START_I while BUSY_O
   is low, and that all inputs come from logic on CLOCK_I.
*/
// Notes on behaviour
// - direct push/pop: +1 state for a port, +2 for a peripheral.
// - direct exchange: +2 states for a port, +3 for a peripheral.
// - wide-access operation: +3 states for a port, +5 for a peripheral.
// - carry jumps: 2 bytes, 1 state not taken, 4 taken, both modes.
// - flag compare jumps: binary 3 bytes 2/5, source 2 bytes 1/4.
// - signed jumps use sign xor overflow, apart from unsigned ones.
// - taken conditional jump, internal execution, odd destination: +1.
// - unconditional jump, internal execution, odd destination: +1.
// - absolute page jump: +2 states when destination is external.
// - long, short, indirect jumps: +3 states to an external target.
// - long jump: 3 bytes, 5 states, operand loads program counter 15:0.
// - short jump: 2 bytes, 4 states, counter plus 2 plus displacement.
// - indirect jump: 1 byte, 5 states, page FFh, accumulator + pointer.
// - no-operation: 1 byte, 1 state, program counter plus one.
`timescale 1ns/1ns
module bet_core
(
   input  wire logic                      CLOCK_I,
   input  wire logic                      RST_N_I,
   input  wire logic                      START_I,
   input  wire bet_pkg::bet_op_t          OP_I,
   input  wire logic                      SRC_MODE_I,
   input  wire logic [bet_pkg::PC_W-1:0]  PC_I,
   input  wire logic [7:0]                REL_I,
   input  wire logic [15:0]               ADDR_I,
   input  wire logic [7:0]                ACC_I,
   input  wire logic [15:0]               DATA_POINTER_REG_I,
   input  wire logic                      CARRY_I,
   input  wire logic                      ZERO_I,
   input  wire logic                      NEG_I,
   input  wire logic                      OVF_I,
   input  wire logic                      INTERNAL_EXEC_I,
   input  wire logic                      EXT_DEST_I,
   input  wire bet_pkg::bet_access_t      ACCESS_I,
   output logic                           BUSY_O,
   output logic                           DONE_O,
   output logic                           TAKEN_O,
   output logic [bet_pkg::CNT_W-1:0]      STATES_O,
   output logic [bet_pkg::BYTES_W-1:0]    BYTES_O,
   output logic [bet_pkg::PC_W-1:0]       NEXT_PC_O
);

   // -----------------------------------------------------------------
   // reset release
   // -----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge CLOCK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // -----------------------------------------------------------------
   // destination, length and condition
   // -----------------------------------------------------------------
   logic                          cond_jump;
   logic                          taken;
   logic [bet_pkg::BYTES_W-1:0]   bytes;
   logic [bet_pkg::PC_W-1:0]      next_pc;

   bet_target u_target
   (
      .op_i               (OP_I),
      .src_mode_i         (SRC_MODE_I),
      .pc_i               (PC_I),
      .rel_i              (REL_I),
      .addr_i             (ADDR_I),
      .acc_i              (ACC_I),
      .data_pointer_reg_i (DATA_POINTER_REG_I),
      .carry_i            (CARRY_I),
      .zero_i             (ZERO_I),
      .neg_i              (NEG_I),
      .ovf_i              (OVF_I),
      .cond_jump_o        (cond_jump),
      .taken_o            (taken),
      .bytes_o            (bytes),
      .next_pc_o          (next_pc)
   );

   // -----------------------------------------------------------------
   // state count
   // -----------------------------------------------------------------
   // picks the port or peripheral surcharge for a direct operand
   function automatic logic [bet_pkg::CNT_W-1:0] access_extra
   (
      input bet_pkg::bet_access_t    acc,
      input logic [bet_pkg::CNT_W-1:0] port_add,
      input logic [bet_pkg::CNT_W-1:0] peri_add
   );
      unique case (acc)
         bet_pkg::ACC_PORT: access_extra = port_add;
         bet_pkg::ACC_PERI: access_extra = peri_add;
         default:           access_extra = bet_pkg::XS_NONE;
      endcase
   endfunction

   logic [bet_pkg::CNT_W-1:0] base_states;
   logic [bet_pkg::CNT_W-1:0] extra_states;
   logic [bet_pkg::CNT_W-1:0] total_states;
   logic                      is_jump;
   logic                      odd_internal;

   // odd internal destination only costs during internal execution
   assign odd_internal = INTERNAL_EXEC_I & ~EXT_DEST_I & next_pc[0];

   always_comb
   begin
      is_jump = 1'b1;
      unique case (OP_I)
         bet_pkg::OP_NO_OPERATION:
         begin
            base_states = bet_pkg::ST_NO_OP;
            is_jump     = 1'b0;
         end
         bet_pkg::OP_JUMP_ON_CARRY_SET,
         bet_pkg::OP_JUMP_ON_CARRY_CLEAR:
            base_states = taken ? bet_pkg::ST_CY_TAKEN
                                : bet_pkg::ST_CY_NOT_TAKEN;
         bet_pkg::OP_ABSOLUTE_PAGE_JUMP:  base_states = bet_pkg::ST_PAGE_JUMP;
         bet_pkg::OP_LONG_16BIT_JUMP:     base_states = bet_pkg::ST_LONG_JUMP;
         bet_pkg::OP_SHORT_RELATIVE_JUMP: base_states = bet_pkg::ST_SHORT_JUMP;
         bet_pkg::OP_ACCUM_POINTER_INDIRECT_JUMP:
            base_states = bet_pkg::ST_IND_JUMP;
         bet_pkg::OP_PUSH_DIRECT:
         begin
            base_states = bet_pkg::ST_PUSH_DIR;
            is_jump     = 1'b0;
         end
         bet_pkg::OP_POP_DIRECT:
         begin
            base_states = bet_pkg::ST_POP_DIR;
            is_jump     = 1'b0;
         end
         bet_pkg::OP_EXCHANGE_WITH_ACCUM:
         begin
            base_states = bet_pkg::ST_EXCH_DIR;
            is_jump     = 1'b0;
         end
         bet_pkg::OP_WIDE_ACCESS_NOTE:
         begin
            base_states = bet_pkg::ST_WIDE_BASE;
            is_jump     = 1'b0;
         end
         default:
         begin
            // the flag compares; not-taken and taken counted apart
            if (SRC_MODE_I)
               base_states = taken ? bet_pkg::ST_CMP_SRC_TK
                                   : bet_pkg::ST_CMP_SRC_NT;
            else
               base_states = taken ? bet_pkg::ST_CMP_BIN_TK
                                   : bet_pkg::ST_CMP_BIN_NT;
         end
      endcase
   end

   always_comb
   begin
      extra_states = bet_pkg::XS_NONE;
      unique case (OP_I)
         bet_pkg::OP_PUSH_DIRECT,
         bet_pkg::OP_POP_DIRECT:
            extra_states = access_extra(ACCESS_I, bet_pkg::XS_STACK_PORT,
                                        bet_pkg::XS_STACK_PERI);
         bet_pkg::OP_EXCHANGE_WITH_ACCUM:
            extra_states = access_extra(ACCESS_I, bet_pkg::XS_EXCH_PORT,
                                        bet_pkg::XS_EXCH_PERI);
         bet_pkg::OP_WIDE_ACCESS_NOTE:
            extra_states = access_extra(ACCESS_I, bet_pkg::XS_WIDE_PORT,
                                        bet_pkg::XS_WIDE_PERI);
         bet_pkg::OP_ABSOLUTE_PAGE_JUMP:
         begin
            if (EXT_DEST_I)
               extra_states = bet_pkg::XS_PAGE_EXT;
            else if (odd_internal)
               extra_states = bet_pkg::XS_ODD_DEST;
         end
         bet_pkg::OP_LONG_16BIT_JUMP,
         bet_pkg::OP_SHORT_RELATIVE_JUMP,
         bet_pkg::OP_ACCUM_POINTER_INDIRECT_JUMP:
         begin
            if (EXT_DEST_I)
               extra_states = bet_pkg::XS_JUMP_EXT;
            else if (odd_internal)
               extra_states = bet_pkg::XS_ODD_DEST;
         end
         default:
         begin
            // only the taken path of a conditional jump pays
            if (cond_jump && taken && odd_internal)
               extra_states = bet_pkg::XS_ODD_DEST;
         end
      endcase
   end

   assign total_states = base_states + extra_states;

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   typedef enum logic [0:0] {
      SEQ_IDLE = 1'b0,
      SEQ_RUN  = 1'b1
   } bet_seq_t;

   bet_seq_t                  seq_reg;
   logic [bet_pkg::CNT_W-1:0] left_reg;
   logic                      done_reg;
   logic                      accept;

   // requests during a run are ignored; the decoder must wait on busy
   assign accept = (seq_reg == SEQ_IDLE) & START_I;
   assign BUSY_O = (seq_reg == SEQ_RUN);
   assign DONE_O = done_reg;

   always_ff @(posedge CLOCK_I or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         seq_reg  <= SEQ_IDLE;
         left_reg <= 4'h0;
         done_reg <= 1'b0;
      end
      else
      begin
         done_reg <= 1'b0;
         unique case (seq_reg)
            SEQ_IDLE:
            begin
               if (accept)
               begin
                  seq_reg  <= SEQ_RUN;
                  left_reg <= total_states;
               end
            end
            SEQ_RUN:
            begin
               left_reg <= left_reg - 4'h1;
               if (left_reg == 4'h1)
               begin
                  seq_reg  <= SEQ_IDLE;
                  done_reg <= 1'b1;
               end
            end
         endcase
      end
   end

   // results captured at acceptance, valid from then until next accept
   always_ff @(posedge CLOCK_I or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         TAKEN_O   <= 1'b0;
         STATES_O  <= 4'h0;
         BYTES_O   <= 3'h0;
         NEXT_PC_O <= 24'h00_0000;
      end
      else if (accept)
      begin
         TAKEN_O   <= taken | is_jump & ~cond_jump;
         STATES_O  <= total_states;
         BYTES_O   <= bytes;
         NEXT_PC_O <= next_pc;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [bet_pkg::CNT_W-1:0] elapsed_reg;

   always_ff @(posedge CLOCK_I or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
         elapsed_reg <= 4'h0;
      else if (accept)
         elapsed_reg <= 4'h1;
      else if (BUSY_O)
         elapsed_reg <= elapsed_reg + 4'h1;
   end

   a_run_length: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      DONE_O |-> $past(elapsed_reg) == STATES_O)
      else $error("run length differs from state count");

   a_stack_port: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_POP_DIRECT && ACCESS_I == bet_pkg::ACC_PORT
      |=> STATES_O == 4'h4 ##4 DONE_O)
      else $error("port pop not four states");

   a_exch_peri: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_EXCHANGE_WITH_ACCUM
      && ACCESS_I == bet_pkg::ACC_PERI |=> STATES_O == 4'h6)
      else $error("peripheral exchange not six states");

   a_wide_peri: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_WIDE_ACCESS_NOTE
      && ACCESS_I == bet_pkg::ACC_PERI |=> STATES_O == 4'h8)
      else $error("peripheral wide access not base plus five");

   a_carry_nt: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_JUMP_ON_CARRY_SET && !CARRY_I
      |=> BYTES_O == 3'h2 && STATES_O == 4'h1 ##1 DONE_O)
      else $error("carry jump not taken timing wrong");

   a_cmp_binary: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_JUMP_ON_EQUAL && !SRC_MODE_I && !ZERO_I
      |=> BYTES_O == 3'h3 && STATES_O == 4'h2
      && NEXT_PC_O == $past(PC_I) + 24'h00_0003)
      else $error("binary compare jump not taken wrong");

   a_signed_lt: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_JUMP_ON_LESS_SIGNED
      |=> TAKEN_O == ($past(NEG_I) != $past(OVF_I)))
      else $error("signed less test wrong");

   a_odd_taken: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_JUMP_ON_CARRY_CLEAR && !CARRY_I
      && INTERNAL_EXEC_I && !EXT_DEST_I && next_pc[0]
      |=> STATES_O == 4'h5)
      else $error("odd destination surcharge missing");

   a_absolute_page_jump_ext: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_ABSOLUTE_PAGE_JUMP && EXT_DEST_I
      |=> STATES_O == 4'h5)
      else $error("external page jump not five states");

   a_nop_step: assert property (@(posedge CLOCK_I) disable iff (!rst_n_reg)
      accept && OP_I == bet_pkg::OP_NO_OPERATION
      |=> !TAKEN_O && NEXT_PC_O == $past(PC_I) + 24'h00_0001
      && BUSY_O ##1 DONE_O && !BUSY_O)
      else $error("no-operation timing or step wrong");

endmodule

// ==== core/bet_target.sv ====
/*
   bet_target: condition test, instruction length and destination address
   for one operation. Purely combinational.
   Assumes the operands are stable in the cycle they are sampled.
*/
`timescale 1ns/1ns
module bet_target
(
   input  wire bet_pkg::bet_op_t          op_i,
   input  wire logic                      src_mode_i,
   input  wire logic [bet_pkg::PC_W-1:0]  pc_i,
   input  wire logic [7:0]                rel_i,
   input  wire logic [15:0]               addr_i,
   input  wire logic [7:0]                acc_i,
   input  wire logic [15:0]               data_pointer_reg_i,
   input  wire logic                      carry_i,
   input  wire logic                      zero_i,
   input  wire logic                      neg_i,
   input  wire logic                      ovf_i,
   output logic                           cond_jump_o,
   output logic                           taken_o,
   output logic [bet_pkg::BYTES_W-1:0]    bytes_o,
   output logic [bet_pkg::PC_W-1:0]       next_pc_o
);

   logic [bet_pkg::PC_W-1:0] pc_adv;
   logic [bet_pkg::PC_W-1:0] rel_ext;
   logic [bet_pkg::PC_W-1:0] pc_two;
   logic                     signed_lt;

   // signed less-than follows sign xor overflow, not carry
   assign signed_lt = neg_i ^ ovf_i;
   assign rel_ext   = {{16{rel_i[7]}}, rel_i};
   assign pc_adv    = pc_i + {21'h00_0000, bytes_o};
   assign pc_two    = pc_i + bet_pkg::PC_STEP_TWO;

   always_comb
   begin
      cond_jump_o = 1'b1;
      taken_o     = 1'b0;
      unique case (op_i)
         bet_pkg::OP_JUMP_ON_CARRY_SET:         taken_o = carry_i;
         bet_pkg::OP_JUMP_ON_CARRY_CLEAR:       taken_o = ~carry_i;
         bet_pkg::OP_JUMP_ON_EQUAL:             taken_o = zero_i;
         bet_pkg::OP_JUMP_ON_UNEQUAL:           taken_o = ~zero_i;
         bet_pkg::OP_JUMP_ON_GREATER_UNSIGNED:  taken_o = ~carry_i & ~zero_i;
         bet_pkg::OP_JUMP_ON_LESS_EQUAL_UNSIGNED: taken_o = carry_i | zero_i;
         bet_pkg::OP_JUMP_ON_LESS_SIGNED:       taken_o = signed_lt;
         bet_pkg::OP_JUMP_ON_LESS_EQUAL_SIGNED: taken_o = signed_lt | zero_i;
         bet_pkg::OP_JUMP_ON_GREATER_SIGNED:    taken_o = ~signed_lt & ~zero_i;
         bet_pkg::OP_JUMP_ON_GREATER_EQUAL_SIGNED: taken_o = ~signed_lt;
         default:
         begin
            cond_jump_o = 1'b0;
            taken_o     = 1'b0;
         end
      endcase
   end

   always_comb
   begin
      unique case (op_i)
         bet_pkg::OP_JUMP_ON_CARRY_SET,
         bet_pkg::OP_JUMP_ON_CARRY_CLEAR:   bytes_o = bet_pkg::BYTES_TWO;
         bet_pkg::OP_NO_OPERATION,
         bet_pkg::OP_ACCUM_POINTER_INDIRECT_JUMP: bytes_o = bet_pkg::BYTES_ONE;
         bet_pkg::OP_LONG_16BIT_JUMP:       bytes_o = bet_pkg::BYTES_THREE;
         default:
         begin
            // flag compares are one byte shorter in source mode
            if (cond_jump_o)
               bytes_o = src_mode_i ? bet_pkg::BYTES_TWO
                                    : bet_pkg::BYTES_THREE;
            else
               bytes_o = bet_pkg::BYTES_TWO;
         end
      endcase
   end

   always_comb
   begin
      unique case (op_i)
         bet_pkg::OP_ABSOLUTE_PAGE_JUMP:
            next_pc_o = {pc_two[23:11], addr_i[10:0]};
         bet_pkg::OP_LONG_16BIT_JUMP:
            next_pc_o = {pc_adv[23:16], addr_i};
         bet_pkg::OP_SHORT_RELATIVE_JUMP:
            next_pc_o = pc_two + rel_ext;
         bet_pkg::OP_ACCUM_POINTER_INDIRECT_JUMP:
            next_pc_o = {bet_pkg::IND_PAGE,
                         {8'h00, acc_i} + data_pointer_reg_i};
         default:
            // advance first, displacement only when the test holds
            next_pc_o = taken_o ? pc_adv + rel_ext : pc_adv;
      endcase
   end

endmodule

// ==== pkg/bet_pkg.sv ====
/*
   bet_pkg: opcodes, access classes, byte counts, state counts and field
   widths shared by the branch and execution timing block.
   Assumes one core clock; one clock edge is one machine state.
*/
package bet_pkg;

   // -----------------------------------------------------------------
   // widths
   // -----------------------------------------------------------------
   localparam int PC_W    = 24;
   localparam int CNT_W   = 4;
   localparam int BYTES_W = 3;

   // -----------------------------------------------------------------
   // operations handed in by the decoder
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NO_OPERATION              = 5'h00,
      OP_JUMP_ON_CARRY_SET         = 5'h01,
      OP_JUMP_ON_CARRY_CLEAR       = 5'h02,
      OP_JUMP_ON_EQUAL             = 5'h03,
      OP_JUMP_ON_UNEQUAL           = 5'h04,
      OP_JUMP_ON_GREATER_UNSIGNED  = 5'h05,
      OP_JUMP_ON_LESS_EQUAL_UNSIGNED = 5'h06,
      OP_JUMP_ON_LESS_SIGNED       = 5'h07,
      OP_JUMP_ON_LESS_EQUAL_SIGNED = 5'h08,
      OP_JUMP_ON_GREATER_SIGNED    = 5'h09,
      OP_JUMP_ON_GREATER_EQUAL_SIGNED = 5'h0A,
      OP_ABSOLUTE_PAGE_JUMP        = 5'h0B,
      OP_LONG_16BIT_JUMP           = 5'h0C,
      OP_SHORT_RELATIVE_JUMP       = 5'h0D,
      OP_ACCUM_POINTER_INDIRECT_JUMP = 5'h0E,
      OP_PUSH_DIRECT               = 5'h0F,
      OP_POP_DIRECT                = 5'h10,
      OP_EXCHANGE_WITH_ACCUM       = 5'h11,
      OP_WIDE_ACCESS_NOTE          = 5'h12
   } bet_op_t;

   // where a direct operand lands
   typedef enum logic [1:0] {
      ACC_MEMORY = 2'h0,
      ACC_PORT   = 2'h1,
      ACC_PERI   = 2'h2
   } bet_access_t;

   // -----------------------------------------------------------------
   // byte counts
   // -----------------------------------------------------------------
   localparam logic [BYTES_W-1:0] BYTES_ONE   = 3'h1;
   localparam logic [BYTES_W-1:0] BYTES_TWO   = 3'h2;
   localparam logic [BYTES_W-1:0] BYTES_THREE = 3'h3;

   // -----------------------------------------------------------------
   // base state counts
   // -----------------------------------------------------------------
   localparam logic [CNT_W-1:0] ST_NO_OP        = 4'h1;
   localparam logic [CNT_W-1:0] ST_CY_NOT_TAKEN = 4'h1;
   localparam logic [CNT_W-1:0] ST_CY_TAKEN     = 4'h4;
   localparam logic [CNT_W-1:0] ST_CMP_BIN_NT   = 4'h2;
   localparam logic [CNT_W-1:0] ST_CMP_BIN_TK   = 4'h5;
   localparam logic [CNT_W-1:0] ST_CMP_SRC_NT   = 4'h1;
   localparam logic [CNT_W-1:0] ST_CMP_SRC_TK   = 4'h4;
   localparam logic [CNT_W-1:0] ST_PAGE_JUMP    = 4'h3;
   localparam logic [CNT_W-1:0] ST_LONG_JUMP    = 4'h5;
   localparam logic [CNT_W-1:0] ST_SHORT_JUMP   = 4'h4;
   localparam logic [CNT_W-1:0] ST_IND_JUMP     = 4'h5;
   localparam logic [CNT_W-1:0] ST_PUSH_DIR     = 4'h2;
   localparam logic [CNT_W-1:0] ST_POP_DIR      = 4'h3;
   localparam logic [CNT_W-1:0] ST_EXCH_DIR     = 4'h3;
   localparam logic [CNT_W-1:0] ST_WIDE_BASE    = 4'h3;

   // -----------------------------------------------------------------
   // extra states
   // -----------------------------------------------------------------
   localparam logic [CNT_W-1:0] XS_STACK_PORT = 4'h1;
   localparam logic [CNT_W-1:0] XS_STACK_PERI = 4'h2;
   localparam logic [CNT_W-1:0] XS_EXCH_PORT  = 4'h2;
   localparam logic [CNT_W-1:0] XS_EXCH_PERI  = 4'h3;
   localparam logic [CNT_W-1:0] XS_WIDE_PORT  = 4'h3;
   localparam logic [CNT_W-1:0] XS_WIDE_PERI  = 4'h5;
   localparam logic [CNT_W-1:0] XS_ODD_DEST   = 4'h1;
   localparam logic [CNT_W-1:0] XS_PAGE_EXT   = 4'h2;
   localparam logic [CNT_W-1:0] XS_JUMP_EXT   = 4'h3;
   localparam logic [CNT_W-1:0] XS_NONE       = 4'h0;

   // -----------------------------------------------------------------
   // fixed fields
   // -----------------------------------------------------------------
   localparam logic [7:0]  IND_PAGE = 8'hFF;
   localparam int          PAGE_LSB_W = 11;
   localparam logic [PC_W-1:0] PC_STEP_TWO = 24'h00_0002;

endpackage

// ==== sim/bet_fetch.sv ====
/*
   bet_fetch: operand source standing in for fetch and program memory.
   Assumes the next instruction is fetched as each one completes.
*/
`timescale 1ns/1ns
module bet_fetch
(
   input  wire logic        clk_i,
   input  wire logic        done_i,
   output logic [23:0]      pc_o,
   output logic [7:0]       rel_o,
   output logic [15:0]      addr_o,
   output logic [7:0]       acc_o,
   output logic [15:0]      dp_o
);
   initial {pc_o, rel_o, addr_o, acc_o, dp_o} = '0;
   // operands only move on completion, never under a running instruction
   always @(posedge clk_i)
      if (done_i)
      begin
         pc_o   <= 24'($urandom);
         rel_o  <= 8'($urandom);
         addr_o <= 16'($urandom);
         acc_o  <= 8'($urandom);
         dp_o   <= 16'($urandom);
      end
endmodule

// ==== sim/branch_exec_timing_bench.sv ====
/*
   branch_exec_timing_bench: random and swept operations, checked against
   computed state counts. Assumes one operation in flight at a time.
*/
`timescale 1ns/1ns
module branch_exec_timing_bench;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, src, c, z, n, v, ie, ext;
   bet_pkg::bet_op_t     op = bet_pkg::OP_NO_OPERATION;
   bet_pkg::bet_access_t acc = bet_pkg::ACC_MEMORY;
   logic busy, done, taken, tk;
   logic [3:0] states, st;
   logic [2:0] bytes, by;
   logic [23:0] npc, np, pc;
   logic [7:0] rel, a8;
   logic [15:0] addr, dp;
   int fails = 0, n_checks = 0, cyc = 0, k, nb;
   initial {src, c, z, n, v, ie, ext} = '0;
   initial forever #20 clk = ~clk;
   bet_core u_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .START_I(start),
      .OP_I(op), .SRC_MODE_I(src), .PC_I(pc), .REL_I(rel), .ADDR_I(addr),
      .ACC_I(a8), .DATA_POINTER_REG_I(dp), .CARRY_I(c), .ZERO_I(z),
      .NEG_I(n), .OVF_I(v), .INTERNAL_EXEC_I(ie), .EXT_DEST_I(ext),
      .ACCESS_I(acc), .BUSY_O(busy), .DONE_O(done), .TAKEN_O(taken),
      .STATES_O(states), .BYTES_O(bytes), .NEXT_PC_O(npc));
   bet_fetch u_mem (.clk_i(clk), .done_i(done), .pc_o(pc), .rel_o(rel),
      .addr_o(addr), .acc_o(a8), .dp_o(dp));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (fails == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         results();
      end
   end
   // sv is the signed less-than reading of the flags
   function automatic void expect_of();
      logic sv;
      logic [9:0] hit;
      int o;
      o = int'(op);
      sv = n ^ v;
      hit = {~sv, ~sv & ~z, sv | z, sv, c | z, ~c & ~z, ~z, z, ~c, c};
      {tk, st, by, np} = {1'b0, 4'h1, 3'h1, pc + 24'h1};
      if (o >= 1 && o <= 10)
      begin
         by = (o > 2 && !src) ? 3'h3 : 3'h2;
         tk = hit[o-1];
         np = pc + 24'(by) + (tk ? {{16{rel[7]}}, rel} : 24'h0);
         st = tk ? 4'(by) + 4'h2 + 4'(ie & !ext & np[0]) : 4'(by) - 4'h1;
      end
      else if (o >= 11 && o <= 14)
      begin
         tk = 1'b1;
         by = (o == 12) ? 3'h3 : (o == 14) ? 3'h1 : 3'h2;
         st = (o == 11) ? 4'h3 : (o == 13) ? 4'h4 : 4'h5;
         np = pc + 24'(by);
         if (o == 11) np[10:0] = addr[10:0];
         if (o == 12) np[15:0] = addr;
         if (o == 13) np = np + {{16{rel[7]}}, rel};
         if (o == 14) np = {8'hff, a8 + dp};
         st = st + (ext ? ((o == 11) ? 4'h2 : 4'h3) : 4'(ie & np[0]));
      end
      else if (o >= 15)
      begin
         st = (o == 15) ? 4'h2 : 4'h3;
         if (acc == bet_pkg::ACC_PORT)
            st = st + ((o == 17) ? 4'h2 : (o == 18) ? 4'h3 : 4'h1);
         if (acc == bet_pkg::ACC_PERI)
            st = st + ((o == 17) ? 4'h3 : (o == 18) ? 4'h5 : 4'h2);
      end
   endfunction
   initial
   begin
      void'($urandom(32'h6d52));
      repeat (12) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (3) @(negedge clk);
      // first pass sweeps every operation code, then random mixes
      for (int i = 0; i < 400; i++)
      begin
         op = bet_pkg::bet_op_t'(i < 19 ? i : $urandom_range(0, 18));
         acc = bet_pkg::bet_access_t'($urandom_range(0, 2));
         {src, c, z, n, v, ie, ext} = 7'($urandom);
         start = 1'b1;
         expect_of();
         @(negedge clk) start = 1'b0;
         k = 0;
         nb = 0;
         while (done !== 1'b1 && k < 20)
         begin
            nb += int'(busy === 1'b1);
            @(negedge clk);
            k++;
         end
         chk(24'(nb), 24'(st));
         chk(24'(states), 24'(st));
         if (int'(op) <= 14)
         begin
            chk(24'(bytes), 24'(by));
            chk(npc, np);
            chk(24'(taken), 24'(tk));
         end
      end
      results();
   end
endmodule
